// ---- include/pmrs_cfg.svh ----
// Register offsets, field positions, reset values and timing counts for the result scaling block
`ifndef PMRS_CFG_SVH
`define PMRS_CFG_SVH
`define PMRS_CLK_HZ 20000000
`define PMRS_OFS_CONFIG 8'h00
`define PMRS_OFS_SHUNT_CAL 8'h04
`define PMRS_OFS_SAMPLE_IN 8'h08
`define PMRS_OFS_SHUNT 8'h0c
`define PMRS_OFS_BUS 8'h10
`define PMRS_OFS_TEMP 8'h14
`define PMRS_OFS_CURRENT 8'h18
`define PMRS_OFS_POWER 8'h1c
`define PMRS_OFS_STATUS 8'h20
`define PMRS_IDX_ID 8'h3f
`define PMRS_CFG_RANGE_BIT 0
`define PMRS_CFG_CT_LSB 1
`define PMRS_CFG_AVG_LSB 4
`define PMRS_CFG_RESET 32'h0000_0000
`define PMRS_CAL_RESET 16'h0000
`define PMRS_ID_WIDTH 12
`define PMRS_REV_WIDTH 4
`define PMRS_CT_MIN_US 50
`endif

// ---- include/pmrs_pkg.sv ----
// Types shared by the result scaling block
package pmrs_pkg;
  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [11:0] temp;
  } pmrs_sample_t;
  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [11:0] temp;
    logic [15:0] current;
    logic [23:0] power;
  } pmrs_result_t;
  typedef enum logic [1:0] {PMRS_IDLE, PMRS_ACC, PMRS_CALC, PMRS_DONE} pmrs_state_t;
endpackage : pmrs_pkg

// ---- rtl/pmrs_conv_timer.sv ----
// Conversion timer: pulses once per selected conversion time
`timescale 1ns/1ns
`include "pmrs_cfg.svh"
module pmrs_conv_timer #(
  parameter int CLK_HZ = `PMRS_CLK_HZ
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] ct_sel,
  output logic tick
);
  localparam int US_CYC = CLK_HZ / 1000000;
  initial begin
    if (US_CYC < 1) $error("clock too slow for microsecond timer");
  end
  function automatic logic [31:0] ct_us(input logic [2:0] s);
    case (s)
      3'h0: ct_us = `PMRS_CT_MIN_US;
      3'h1: ct_us = 84;
      3'h2: ct_us = 150;
      3'h3: ct_us = 280;
      3'h4: ct_us = 540;
      3'h5: ct_us = 1052;
      3'h6: ct_us = 2074;
      default: ct_us = 4120;
    endcase
  endfunction : ct_us
  logic [31:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [31:0] limit;
  always_comb begin
    limit = ct_us(ct_sel) * 32'(US_CYC);
    tick_d = 1'b0;
    cnt_d = cnt_q + 32'h1;
    if (cnt_q + 32'h1 >= limit) begin
      cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule : pmrs_conv_timer

// ---- rtl/pmrs_result_mem.sv ----
// Small register memory holding the averaged results, read data registered
`timescale 1ns/1ns
module pmrs_result_mem #(
  parameter int W = 104
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q, mem_d;
  logic [W-1:0] rd_q;
  always_comb begin
    mem_d = wr_en ? wr_data : mem_q;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= '0;
      rd_q <= '0;
    end else begin
      mem_q <= mem_d;
      rd_q <= mem_q;
    end
  end
  assign rd_data = rd_q;
endmodule : pmrs_result_mem

// ---- rtl/pmrs_top.sv ----
// Result scaling core: averaging, current and power, Avalon-MM register slave
`timescale 1ns/1ns
`include "pmrs_cfg.svh"
module pmrs_top #(
  parameter int CLK_HZ = `PMRS_CLK_HZ,
  parameter logic [11:0] DEV_ID = 12'h5a5, // Arbitrary value
  parameter logic [3:0] REVISION_FIELD_VAL = 4'h3 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_readdatavalid_unused,
  input wire logic [15:0] adc_shunt,
  input wire logic [15:0] adc_bus,
  input wire logic [11:0] adc_temp,
  output logic sample_ready
);
  initial begin
    if (CLK_HZ < 1000000) $error("ref_clk below 1 MHz not supported");
  end
  // Config register
  logic [31:0] cfg_q, cfg_d;
  logic [15:0] cal_q, cal_d;
  logic shunt_range_select;
  logic [2:0] ct_sel;
  logic [3:0] avg_sel;
  assign shunt_range_select = cfg_q[`PMRS_CFG_RANGE_BIT];
  assign ct_sel = cfg_q[`PMRS_CFG_CT_LSB +: 3];
  assign avg_sel = cfg_q[`PMRS_CFG_AVG_LSB +: 4];

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    be_merge = r;
  endfunction : be_merge

  function automatic logic [10:0] avg_count(input logic [3:0] s);
    case (s[2:0])
      3'h0: avg_count = 11'd1;
      3'h1: avg_count = 11'd4;
      3'h2: avg_count = 11'd16;
      3'h3: avg_count = 11'd64;
      3'h4: avg_count = 11'd128;
      3'h5: avg_count = 11'd256;
      3'h6: avg_count = 11'd512;
      default: avg_count = 11'd1024;
    endcase
  endfunction : avg_count

  function automatic logic [3:0] avg_shift(input logic [3:0] s);
    case (s[2:0])
      3'h0: avg_shift = 4'd0;
      3'h1: avg_shift = 4'd2;
      3'h2: avg_shift = 4'd4;
      3'h3: avg_shift = 4'd6;
      3'h4: avg_shift = 4'd7;
      3'h5: avg_shift = 4'd8;
      3'h6: avg_shift = 4'd9;
      default: avg_shift = 4'd10;
    endcase
  endfunction : avg_shift

  function automatic logic [15:0] adc_tmp_ext(input logic [11:0] t);
    adc_tmp_ext = {{4{t[11]}}, t};
  endfunction : adc_tmp_ext

  // Conversion timing; timer limit follows conversion time selection
  logic conv_tick;
  pmrs_conv_timer #(.CLK_HZ(CLK_HZ)) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ct_sel(ct_sel),
    .tick(conv_tick)
  );

  // Averaging and calculation
  pmrs_pkg::pmrs_state_t st_q, st_d;
  logic signed [26:0] acc_sh_q, acc_sh_d;
  logic [26:0] acc_bus_q, acc_bus_d;
  logic signed [22:0] acc_tmp_q, acc_tmp_d;
  logic [10:0] n_q, n_d;
  pmrs_pkg::pmrs_result_t res_q, res_d;
  logic wr_q, wr_d;
  logic rdy_q, rdy_d;
  logic signed [47:0] cur_full;
  logic [15:0] cur_abs;
  logic [39:0] pwr_full;

  always_comb begin
    st_d = st_q;
    acc_sh_d = acc_sh_q;
    acc_bus_d = acc_bus_q;
    acc_tmp_d = acc_tmp_q;
    n_d = n_q;
    res_d = res_q;
    wr_d = 1'b0;
    rdy_d = 1'b0;
    cur_full = '0;
    cur_abs = '0;
    pwr_full = '0;
    unique case (st_q)
      pmrs_pkg::PMRS_IDLE, pmrs_pkg::PMRS_ACC: begin
        if (conv_tick) begin
          // Signed shunt and temperature, unsigned bus
          acc_sh_d = acc_sh_q + 27'(signed'(adc_shunt));
          acc_bus_d = acc_bus_q + 27'(adc_bus);
          acc_tmp_d = acc_tmp_q + 23'(signed'(adc_tmp_ext(adc_temp)));
          n_d = n_q + 11'd1;
          st_d = pmrs_pkg::PMRS_ACC;
          if (n_q + 11'd1 >= avg_count(avg_sel)) begin
            st_d = pmrs_pkg::PMRS_CALC;
          end
        end
      end
      pmrs_pkg::PMRS_CALC: begin
        // Window closed: commit all averaged results at once
        res_d.shunt = 16'(acc_sh_q >>> avg_shift(avg_sel));
        res_d.bus = 16'(acc_bus_q >> avg_shift(avg_sel));
        res_d.temp = 12'(acc_tmp_q >>> avg_shift(avg_sel));
        // Current from the averaged shunt result and calibration; range bit not used here, narrow range relies on software writing 4x cal
        cur_full = 48'(signed'(res_d.shunt)) * 48'(signed'({1'b0, cal_q}));
        if (cal_q == 16'h0) begin
          res_d.current = 16'h0;
        end else begin
          res_d.current = 16'(cur_full >>> 11);
        end
        cur_abs = res_d.current[15] ? 16'(-res_d.current) : res_d.current;
        // Unsigned 24-bit power, saturating, units of 16 current steps times bus step
        pwr_full = 40'(cur_abs) * 40'(res_d.bus);
        res_d.power = (pwr_full[39:4] > 36'hff_ffff) ? 24'hff_ffff : 24'(pwr_full >> 4);
        wr_d = 1'b1;
        st_d = pmrs_pkg::PMRS_DONE;
      end
      pmrs_pkg::PMRS_DONE: begin
        acc_sh_d = '0;
        acc_bus_d = '0;
        acc_tmp_d = '0;
        n_d = '0;
        rdy_d = 1'b1;
        st_d = pmrs_pkg::PMRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= pmrs_pkg::PMRS_IDLE;
      acc_sh_q <= '0;
      acc_bus_q <= '0;
      acc_tmp_q <= '0;
      n_q <= '0;
      res_q <= '0;
      wr_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      acc_sh_q <= acc_sh_d;
      acc_bus_q <= acc_bus_d;
      acc_tmp_q <= acc_tmp_d;
      n_q <= n_d;
      res_q <= res_d;
      wr_q <= wr_d;
      rdy_q <= rdy_d;
    end
  end
  assign sample_ready = rdy_q;

  // Results visible to software through a registered store
  pmrs_pkg::pmrs_result_t res_vis;
  pmrs_result_mem #(.W($bits(pmrs_pkg::pmrs_result_t))) u_mem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(wr_q),
    .wr_data(res_q),
    .rd_data(res_vis)
  );

  // Avalon slave: one wait cycle, answer on the second edge
  logic busy_q, busy_d;
  logic wait_q, wait_d;
  logic rdv_q, rdv_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] rsel;
  always_comb begin
    cfg_d = cfg_q;
    cal_d = cal_q;
    busy_d = 1'b0;
    rdv_d = 1'b0;
    rdata_d = rdata_q;
    rsel = 32'h0;
    unique case (avs_address)
      `PMRS_OFS_CONFIG: rsel = {25'h0, cfg_q[6:0]};
      `PMRS_OFS_SHUNT_CAL: rsel = {16'h0, cal_q};
      `PMRS_OFS_SHUNT: rsel = {16'h0, res_vis.shunt};
      `PMRS_OFS_BUS: rsel = {16'h0, res_vis.bus};
      `PMRS_OFS_TEMP: rsel = {16'h0, res_vis.temp, 4'h0};
      `PMRS_OFS_CURRENT: rsel = {16'h0, res_vis.current};
      `PMRS_OFS_POWER: rsel = {8'h0, res_vis.power};
      `PMRS_OFS_STATUS: rsel = {29'h0, shunt_range_select, st_q};
      8'(`PMRS_IDX_ID * 4): rsel = {16'h0, DEV_ID, REVISION_FIELD_VAL};
      default: rsel = 32'h0;
    endcase
    if ((avs_read || avs_write) && !busy_q) begin
      busy_d = 1'b1;
      rdata_d = rsel;
    end
    // Writes land on the edge where the master sees waitrequest low, not when taken
    if (avs_write && busy_q) begin
      if (avs_address == `PMRS_OFS_CONFIG) begin
        // Range bit only changes step size reading, not the stored codes
        cfg_d = be_merge(cfg_q, avs_writedata, avs_byteenable) & 32'h0000_007f;
      end
      if (avs_address == `PMRS_OFS_SHUNT_CAL) begin
        cal_d = 16'(be_merge({16'h0, cal_q}, avs_writedata, avs_byteenable));
      end
    end
    wait_d = !busy_d;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= `PMRS_CFG_RESET;
      cal_q <= `PMRS_CAL_RESET;
      busy_q <= 1'b0;
      wait_q <= 1'b1;
      rdv_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      cal_q <= cal_d;
      busy_q <= busy_d;
      wait_q <= wait_d;
      rdv_q <= rdv_d;
      rdata_q <= rdata_d;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  // Fixed-latency slave: waitrequest alone frames each transfer
  assign avs_readdatavalid_unused = rdv_q;

  property p_zero_cal;
    @(posedge ref_clk) disable iff (!reset_n) (st_q == pmrs_pkg::PMRS_CALC && cal_q == 16'h0) |=> res_q.current == 16'h0;
  endproperty
  a_zero_cal: assert property (p_zero_cal) else $error("current not zero with zero cal");
  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n) (st_q != pmrs_pkg::PMRS_CALC) |=> $stable(res_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed mid window");
  property p_commit;
    @(posedge ref_clk) disable iff (!reset_n) (st_q == pmrs_pkg::PMRS_CALC) |=> wr_q ##1 rdy_q;
  endproperty
  a_commit: assert property (p_commit) else $error("commit sequence broken");
  property p_avg;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(st_q == pmrs_pkg::PMRS_CALC) |-> $past(n_q) + 11'd1 >= avg_count($past(avg_sel));
  endproperty
  a_avg: assert property (p_avg) else $error("window ended early");
  property p_pwr;
    @(posedge ref_clk) disable iff (!reset_n) (res_q.bus == 16'h0) |-> res_q.power == 24'h0;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power nonzero at zero bus");
  property p_id;
    @(posedge ref_clk) disable iff (!reset_n) (avs_read && busy_q && avs_address == 8'hfc) |-> avs_readdata == {16'h0, DEV_ID, REVISION_FIELD_VAL};
  endproperty
  a_id: assert property (p_id) else $error("identity word wrong");
  property p_wait;
    @(posedge ref_clk) disable iff (!reset_n) (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("slave did not answer in one cycle");
  property p_tick;
    @(posedge ref_clk) disable iff (!reset_n) conv_tick |=> !conv_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("conversion ticks too close");
  property p_cal_wr;
    @(posedge ref_clk) disable iff (!reset_n) (avs_write && !avs_waitrequest && avs_address == `PMRS_OFS_SHUNT_CAL
      && avs_byteenable == 4'hf) |=> cal_q == $past(avs_writedata[15:0]);
  endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("calibration write lost");
  c_commit: cover property (@(posedge ref_clk) disable iff (!reset_n) rdy_q);
  c_write: cover property (@(posedge ref_clk) disable iff (!reset_n) avs_write && !avs_waitrequest);
  c_neg: cover property (@(posedge ref_clk) disable iff (!reset_n) res_q.current[15]);
  c_narrow: cover property (@(posedge ref_clk) disable iff (!reset_n) shunt_range_select && rdy_q);
endmodule : pmrs_top

// ---- verif/pmrs_host_model.sv ----
// Host-side model: Avalon-MM master and calibration helper
`timescale 1ns/1ns
module pmrs_host_model (
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  int hangs = 0;

  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end

  // Narrow range needs four times the wide-range value
  function automatic logic [15:0] cal_for_range(input logic [15:0] wide_cal, input logic narrow);
    return narrow ? {wide_cal[13:0], 2'b00} : wide_cal;
  endfunction : cal_for_range

  // Call just after a rising edge; holds the request until waitrequest is sampled low
  task automatic access(input logic [7:0] addr, input logic is_wr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
    int n;
    n = 0;
    avs_address <= addr;
    avs_read <= !is_wr;
    avs_write <= is_wr;
    avs_writedata <= wdata;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      hangs++;
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines carry no stale value
    avs_address <= ~addr;
    avs_writedata <= ~wdata;
    @(posedge ref_clk);
  endtask : access
endmodule : pmrs_host_model

// ---- verif/test_pmrs_top.sv ----
// Self-checking bench for the result scaling block
`timescale 1ns/1ns
module test_pmrs_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] adc_shunt;
  logic [15:0] adc_bus;
  logic [11:0] adc_temp;
  logic sample_ready;
  logic [31:0] rd;
  int num_errors = 0;
  int checked = 0;
  int cyc;
  int ct_us [4] = '{50, 84, 150, 280};

  always #25 ref_clk = ~ref_clk;

  pmrs_host_model host (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));

  // Arbitrary identity values
  pmrs_top #(.DEV_ID(12'h6c1), .REVISION_FIELD_VAL(4'h2)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_readdatavalid_unused(), .adc_shunt(adc_shunt), .adc_bus(adc_bus), .adc_temp(adc_temp),
    .sample_ready(sample_ready));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A bus timeout ends the run at once
  task automatic bus_guard();
    if (host.hangs > 0) begin
      num_errors++;
      $display("mismatch bus access expected answer seen timeout");
      tally_and_finish();
    end
  endtask : bus_guard

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp,
                        input string what);
    host.access(addr, 1'b0, 32'h0000_0000, rd);
    bus_guard();
    check(what, rd & mask, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    host.access(addr, 1'b1, data, rd);
    bus_guard();
  endtask : wr

  // Bounded wait; returns at the edge that samples the pulse
  task automatic wait_ready();
    for (int i = 0; i < 20000; i++) begin
      @(posedge ref_clk);
      if (sample_ready === 1'b1) begin
        return;
      end
    end
    num_errors++;
    $display("mismatch sample_ready expected pulse seen none");
    tally_and_finish();
  endtask : wait_ready

  task automatic fresh_sample();
    wait_ready();
    wait_ready();
    repeat (3) @(posedge ref_clk);
  endtask : fresh_sample

  task automatic measure(output int n);
    wait_ready();
    n = 0;
    for (int i = 0; i < 20000; i++) begin
      @(posedge ref_clk);
      n++;
      if (sample_ready === 1'b1) begin
        return;
      end
    end
  endtask : measure

  initial begin
    adc_shunt <= 16'hff38;
    adc_bus <= 16'h1000;
    adc_temp <= 12'hf38;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd_chk(8'hfc, 32'h0000_ffff, 32'h0000_6c12, "identity");
    wr(8'hfc, 32'h0000_0000);
    rd_chk(8'hfc, 32'h0000_ffff, 32'h0000_6c12, "identity after write");
    rd_chk(8'h80, 32'hffff_ffff, 32'h0000_0000, "unmapped");
    rd_chk(8'h00, 32'h0000_007f, 32'h0000_0000, "config reset");
    rd_chk(8'h04, 32'h0000_ffff, 32'h0000_0000, "cal reset");
    fresh_sample();
    rd_chk(8'h0c, 32'h0000_ffff, 32'h0000_ff38, "shunt");
    rd_chk(8'h10, 32'h0000_ffff, 32'h0000_1000, "bus");
    rd_chk(8'h14, 32'h0000_fff0, 32'h0000_f380, "temp");
    rd_chk(8'h18, 32'h0000_ffff, 32'h0000_0000, "current zero cal");
    $display("test formats done");
    // Round step: current reads as the shunt code itself
    wr(8'h04, 32'h0000_0800);
    fresh_sample();
    rd_chk(8'h18, 32'h0000_ffff, 32'h0000_ff38, "current");
    rd_chk(8'h1c, 32'h00ff_ffff, 32'h0000_c800, "power");
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, {16'h0000, host.cal_for_range(16'h0800, 1'b1)});
    fresh_sample();
    rd_chk(8'h00, 32'h0000_0001, 32'h0000_0001, "range select");
    rd_chk(8'h18, 32'h0000_ffff, 32'h0000_fce0, "narrow current");
    rd_chk(8'h1c, 32'h00ff_ffff, 32'h0003_2000, "narrow power");
    $display("test current and power done");
    wr(8'h00, 32'h0000_0010);
    wr(8'h04, 32'h0000_0800);
    measure(cyc);
    check("avg period", cyc, 32'd4000);
    @(posedge ref_clk);
    adc_shunt <= 16'h0190;
    repeat (2000) @(posedge ref_clk);
    rd_chk(8'h0c, 32'h0000_ffff, 32'h0000_ff38, "held shunt");
    fresh_sample();
    rd_chk(8'h0c, 32'h0000_ffff, 32'h0000_0190, "averaged shunt");
    $display("test averaging done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'(i) << 1);
      measure(cyc);
      check("conversion period", cyc, 32'(ct_us[i] * 20));
    end
    $display("test conversion times done");
    check("bus hangs", host.hangs, 32'd0);
    tally_and_finish();
  end
endmodule : test_pmrs_top
